/* File: rtl/nbm_manager.sv */
// Host-side bad-block manager placed above a NAND operation engine
`timescale 1ns/1ns
module nbm_manager
    import nbm_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire nbm_cmd_type cmd,
    output logic rsp_valid,
    output nbm_rsp_type rsp,
    output logic fl_valid,
    input wire logic fl_ready,
    output nbm_freq_type fl_req,
    input wire logic fl_done,
    input wire nbm_frsp_type fl_rsp,
    output logic scan_done,
    output logic scan_ok,
    output logic [10:0] bad_count
);
    typedef enum logic [3:0]
    {
        ST_SCAN_REQ = 4'h0,
        ST_SCAN_WAIT = 4'h1,
        ST_SCAN_WR = 4'h2,
        ST_IDLE = 4'h3,
        ST_LOOK = 4'h4,
        ST_CHECK = 4'h5,
        ST_OP_REQ = 4'h6,
        ST_OP_WAIT = 4'h7,
        ST_STAT_REQ = 4'h8,
        ST_STAT_WAIT = 4'h9,
        ST_RESP = 4'hA
    } nbm_state_type;

    nbm_state_type state_ff, nxt_state;
    nbm_uop_type uop_ff, nxt_uop;
    nbm_fop_type fop_ff, nxt_fop;
    nbm_rc_type code_ff, nxt_code;
    logic [9:0] blk_ff, nxt_blk;
    logic [5:0] pg_ff, nxt_pg;
    logic mark_ff, nxt_mark;
    logic scan_done_ff;
    logic [10:0] bad_cnt_ff;
    logic [9:0] open_blk_ff;
    logic [5:0] open_pg_ff;
    logic open_vld_ff;

    wire logic rd_bad;
    wire logic wr_en;
    wire logic wr_bad;
    wire logic marker_bad;
    wire logic order_bad;
    wire logic is_write_op;
    wire logic stat_fail;
    wire logic [10:0] valid_cnt;

    assign marker_bad = fl_rsp.data != NBM_MARK_GOOD;
    // Only the last programmed block is tracked: one entry, hopping restarts it
    assign order_bad = open_vld_ff && (blk_ff == open_blk_ff)
        && (pg_ff <= open_pg_ff);
    assign is_write_op = uop_ff != NBM_UOP_READ;
    assign stat_fail = fl_rsp.data[NBM_STAT_FAIL_BIT];
    assign wr_en = (state_ff == ST_SCAN_WR)
        || (state_ff == ST_RESP && code_ff == NBM_RC_FAIL);
    assign wr_bad = (state_ff == ST_SCAN_WR) ? mark_ff : 1'b1;
    assign valid_cnt = NBM_TOTAL_BLOCKS - bad_cnt_ff;
    assign cmd_ready = state_ff == ST_IDLE;
    assign rsp_valid = state_ff == ST_RESP;
    assign rsp = '{code: code_ff, blk: blk_ff, pg: pg_ff};
    assign fl_valid = (state_ff == ST_SCAN_REQ) || (state_ff == ST_OP_REQ)
        || (state_ff == ST_STAT_REQ);
    assign fl_req = '{fop: fop_ff, blk: blk_ff, pg: pg_ff};
    assign scan_done = scan_done_ff;
    assign scan_ok = scan_done_ff && (valid_cnt >= NBM_MIN_VALID);
    assign bad_count = bad_cnt_ff;
    nbm_bbt_mem #(.DEPTH(NBM_BLOCKS), .AW(NBM_BLK_W)) u_bbt
    (
        .mclk(mclk),
        .nrst(nrst),
        .wr_en(wr_en),
        .wr_addr(blk_ff),
        .wr_bad(wr_bad),
        .rd_addr(blk_ff),
        .rd_bad(rd_bad)
    );
    always_comb
    begin
        nxt_state = state_ff;
        nxt_uop = uop_ff;
        nxt_fop = fop_ff;
        nxt_code = code_ff;
        nxt_blk = blk_ff;
        nxt_pg = pg_ff;
        nxt_mark = mark_ff;
        unique case (state_ff)
            ST_SCAN_REQ:
                if (fl_ready)
                    nxt_state = ST_SCAN_WAIT;
            ST_SCAN_WAIT:
                if (fl_done)
                begin
                    nxt_mark = marker_bad;
                    if (marker_bad || pg_ff == NBM_MARK_PAGE1)
                        nxt_state = ST_SCAN_WR;
                    else
                    begin
                        nxt_pg = NBM_MARK_PAGE1;
                        nxt_state = ST_SCAN_REQ;
                    end
                end
            ST_SCAN_WR:
                if (blk_ff == NBM_LAST_BLOCK)
                begin
                    nxt_pg = NBM_MARK_PAGE0;
                    nxt_state = ST_IDLE;
                end
                else
                begin
                    nxt_blk = blk_ff + 10'h001;
                    nxt_pg = NBM_MARK_PAGE0;
                    nxt_fop = NBM_FOP_MARK;
                    nxt_state = ST_SCAN_REQ;
                end
            ST_IDLE:
                if (cmd_valid)
                begin
                    nxt_uop = cmd.uop;
                    nxt_blk = cmd.blk;
                    nxt_pg = cmd.pg;
                    nxt_state = ST_LOOK;
                end
            ST_LOOK:
                nxt_state = ST_CHECK;
            ST_CHECK:
                if (is_write_op && rd_bad)
                begin
                    nxt_code = NBM_RC_BAD_BLOCK;
                    nxt_state = ST_RESP;
                end
                else if (uop_ff == NBM_UOP_PROG && order_bad)
                begin
                    nxt_code = NBM_RC_ORDER;
                    nxt_state = ST_RESP;
                end
                else
                begin
                    nxt_fop = (uop_ff == NBM_UOP_PROG) ? NBM_FOP_PROG
                        : (uop_ff == NBM_UOP_ERASE) ? NBM_FOP_ERASE : NBM_FOP_READ;
                    nxt_state = ST_OP_REQ;
                end
            ST_OP_REQ:
                if (fl_ready)
                    nxt_state = ST_OP_WAIT;
            ST_OP_WAIT:
                if (fl_done)
                begin
                    if (!is_write_op)
                    begin
                        nxt_code = fl_rsp.ecc_uncor ? NBM_RC_ECC_UNCOR
                            : fl_rsp.ecc_fixed ? NBM_RC_ECC_FIXED : NBM_RC_OK;
                        nxt_state = ST_RESP;
                    end
                    else
                    begin
                        nxt_fop = NBM_FOP_STATUS;
                        nxt_state = ST_STAT_REQ;
                    end
                end
            ST_STAT_REQ:
                if (fl_ready)
                    nxt_state = ST_STAT_WAIT;
            ST_STAT_WAIT:
                if (fl_done)
                begin
                    nxt_code = stat_fail ? NBM_RC_FAIL : NBM_RC_OK;
                    nxt_state = ST_RESP;
                end
            ST_RESP:
                nxt_state = ST_IDLE;
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    // Reset lands in the table-write state for block zero, marked good
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_ff <= ST_SCAN_WR;
            uop_ff <= NBM_UOP_READ;
            fop_ff <= NBM_FOP_MARK;
            code_ff <= NBM_RC_OK;
            blk_ff <= NBM_BOOT_BLOCK;
            pg_ff <= NBM_MARK_PAGE0;
            mark_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            uop_ff <= nxt_uop;
            fop_ff <= nxt_fop;
            code_ff <= nxt_code;
            blk_ff <= nxt_blk;
            pg_ff <= nxt_pg;
            mark_ff <= nxt_mark;
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            scan_done_ff <= 1'b0;
        else if (state_ff == ST_SCAN_WR && blk_ff == NBM_LAST_BLOCK)
            scan_done_ff <= 1'b1;
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            bad_cnt_ff <= 11'h000;
        else if (wr_en && wr_bad)
            bad_cnt_ff <= bad_cnt_ff + 11'h001;
    end

    // Erasing the open block lets programming restart anywhere in it
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            open_vld_ff <= 1'b0;
            open_blk_ff <= 10'h000;
            open_pg_ff <= 6'h00;
        end
        else if (state_ff == ST_OP_REQ && fl_ready && fop_ff == NBM_FOP_PROG)
        begin
            open_vld_ff <= 1'b1;
            open_blk_ff <= blk_ff;
            open_pg_ff <= pg_ff;
        end
        else if (state_ff == ST_OP_REQ && fl_ready && fop_ff == NBM_FOP_ERASE
            && blk_ff == open_blk_ff)
            open_vld_ff <= 1'b0;
    end

    a_boot_block_good: assert property (@(posedge mclk) disable iff (!nrst)
        (state_ff == ST_SCAN_WR && blk_ff == NBM_BOOT_BLOCK) |-> !wr_bad)
        else $error("block zero written as bad during scan");
    a_marker_bad: assert property (@(posedge mclk) disable iff (!nrst)
        (state_ff == ST_SCAN_WAIT && fl_done && marker_bad)
        |=> (state_ff == ST_SCAN_WR && wr_en && wr_bad))
        else $error("bad marker not recorded");
    a_scan_first: assert property (@(posedge mclk) disable iff (!nrst)
        (fl_valid && (fl_req.fop == NBM_FOP_PROG || fl_req.fop == NBM_FOP_ERASE))
        |-> scan_done_ff)
        else $error("program or erase before scan completed");
    a_bad_refused: assert property (@(posedge mclk) disable iff (!nrst)
        (state_ff == ST_CHECK && rd_bad && is_write_op)
        |=> (rsp_valid && rsp.code == NBM_RC_BAD_BLOCK) ##1 cmd_ready)
        else $error("operation on bad block not refused");
    a_status_follows: assert property (@(posedge mclk) disable iff (!nrst)
        (state_ff == ST_OP_WAIT && fl_done && is_write_op)
        |=> (fl_valid && fl_req.fop == NBM_FOP_STATUS))
        else $error("no status read after program or erase");
    a_fail_retire: assert property (@(posedge mclk) disable iff (!nrst)
        (state_ff == ST_STAT_WAIT && fl_done && stat_fail)
        |=> (rsp_valid && rsp.code == NBM_RC_FAIL) ##1 (bad_cnt_ff == $past(bad_cnt_ff) + 11'h001))
        else $error("failed block not retired");
    a_ecc_report: assert property (@(posedge mclk) disable iff (!nrst)
        (state_ff == ST_OP_WAIT && fl_done && !is_write_op && fl_rsp.ecc_uncor)
        |=> (rsp_valid && rsp.code == NBM_RC_ECC_UNCOR))
        else $error("uncorrectable read not reported");
    a_order_kept: assert property (@(posedge mclk) disable iff (!nrst)
        (fl_valid && fl_ready && fl_req.fop == NBM_FOP_PROG && open_vld_ff
        && fl_req.blk == open_blk_ff) |-> (fl_req.pg > open_pg_ff))
        else $error("program page not ascending");
    c_scan_end: cover property (@(posedge mclk) disable iff (!nrst)
        $rose(scan_done_ff));
    c_prog_fail: cover property (@(posedge mclk) disable iff (!nrst)
        rsp_valid && rsp.code == NBM_RC_FAIL);
    c_order_refused: cover property (@(posedge mclk) disable iff (!nrst)
        rsp_valid && rsp.code == NBM_RC_ORDER);
    c_read_fixed: cover property (@(posedge mclk) disable iff (!nrst)
        rsp_valid && rsp.code == NBM_RC_ECC_FIXED);
endmodule

/* File: rtl/nbm_pkg.sv */
// Shared constants and carrier types for the NAND bad-block manager
package nbm_pkg;
    localparam int NBM_BLOCKS = 1024;
    localparam int NBM_BLK_W = 10;
    localparam int NBM_PG_W = 6;
    localparam logic [10:0] NBM_TOTAL_BLOCKS = 11'h400;
    localparam logic [10:0] NBM_MIN_VALID = 11'h3EC;
    localparam logic [9:0] NBM_BOOT_BLOCK = 10'h000;
    localparam logic [9:0] NBM_LAST_BLOCK = 10'h3FF;
    localparam logic [5:0] NBM_MARK_PAGE0 = 6'h00;
    localparam logic [5:0] NBM_MARK_PAGE1 = 6'h01;
    localparam logic [7:0] NBM_MARK_GOOD = 8'hFF;
    localparam int NBM_STAT_FAIL_BIT = 0;
    localparam int NBM_ECC_UNIT_BYTES = 528;
    localparam int NBM_ECC_MIN_BITS = 1;

    typedef enum logic [2:0]
    {
        NBM_FOP_READ = 3'h0,
        NBM_FOP_PROG = 3'h1,
        NBM_FOP_ERASE = 3'h2,
        NBM_FOP_STATUS = 3'h3,
        NBM_FOP_MARK = 3'h4
    } nbm_fop_type;

    typedef enum logic [1:0]
    {
        NBM_UOP_READ = 2'h0,
        NBM_UOP_PROG = 2'h1,
        NBM_UOP_ERASE = 2'h2
    } nbm_uop_type;

    typedef enum logic [2:0]
    {
        NBM_RC_OK = 3'h0,
        NBM_RC_BAD_BLOCK = 3'h1,
        NBM_RC_ORDER = 3'h2,
        NBM_RC_FAIL = 3'h3,
        NBM_RC_ECC_FIXED = 3'h4,
        NBM_RC_ECC_UNCOR = 3'h5
    } nbm_rc_type;

    typedef struct packed
    {
        nbm_fop_type fop;
        logic [9:0] blk;
        logic [5:0] pg;
    } nbm_freq_type;

    typedef struct packed
    {
        logic [7:0] data;
        logic ecc_fixed;
        logic ecc_uncor;
    } nbm_frsp_type;

    typedef struct packed
    {
        nbm_uop_type uop;
        logic [9:0] blk;
        logic [5:0] pg;
    } nbm_cmd_type;

    typedef struct packed
    {
        nbm_rc_type code;
        logic [9:0] blk;
        logic [5:0] pg;
    } nbm_rsp_type;
endpackage

/* File: rtl/nbm_bbt_mem.sv */
// One bit per block bad-block table with registered read
`timescale 1ns/1ns
module nbm_bbt_mem
#(
    parameter int DEPTH = 1024,
    parameter int AW = 10
)
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic wr_bad,
    input wire logic [AW-1:0] rd_addr,
    output logic rd_bad
);
    logic mem_ff [DEPTH];
    logic rd_bad_ff;

    // Array has no reset; the startup scan writes every entry
    always_ff @(posedge mclk)
    begin
        if (wr_en)
            mem_ff[wr_addr] <= wr_bad;
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            rd_bad_ff <= 1'b0;
        else
            rd_bad_ff <= mem_ff[rd_addr];
    end

    assign rd_bad = rd_bad_ff;
endmodule

/* File: sim/nbm_flash_model.sv */
// Behavioural NAND operation engine with factory markers and fault injection
`timescale 1ns/1ns
module nbm_flash_model
    import nbm_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic fl_valid,
    output logic fl_ready,
    input wire nbm_freq_type fl_req,
    output logic fl_done,
    output nbm_frsp_type fl_rsp,
    input wire logic [9:0] fail_blk,
    input wire logic slow,
    output logic [7:0] viol_ff
);
    logic busy_ff;
    logic [2:0] cnt_ff;
    nbm_freq_type req_ff;
    logic [9:0] last_blk_ff;
    nbm_frsp_type last_ff;
    nbm_frsp_type ans;
    logic [6:0] pg_ff [1024];
    wire accept = fl_valid && fl_ready;
    wire is_prog = fl_req.fop == NBM_FOP_PROG;
    wire is_erase = fl_req.fop == NBM_FOP_ERASE;
    wire [6:0] prev = pg_ff[fl_req.blk];
    logic [10:0] scanned_ff;
    logic stat_due_ff;
    wire is_status = fl_req.fop == NBM_FOP_STATUS;
    // Host slips that the manager must never make
    wire early_write = (is_prog || is_erase) && scanned_ff < 11'h3FF;
    wire stat_skip = stat_due_ff != is_status;
    wire bad_order = is_prog && prev[6] && fl_req.pg <= prev[5:0];

    // Block 0 always reads good; three blocks carry factory marks
    function automatic logic [7:0] marker(input logic [9:0] b, input logic [5:0] p);
        if (b == 10'h005 && p == 6'h00) return 8'h00;
        if (b == 10'h009 && p == 6'h01) return 8'hF0;
        if (b == 10'h3FF && p == 6'h00) return 8'h5A;
        return 8'hFF;
    endfunction

    wire mark_bad = marker(fl_req.blk, 6'h00) != 8'hFF || marker(fl_req.blk, 6'h01) != 8'hFF;
    wire bad_erase = is_erase && mark_bad;
    assign fl_ready = !busy_ff;
    assign fl_done = busy_ff && cnt_ff == 3'h0;
    // Released data shows the inverse so a stale sample cannot match
    assign fl_rsp = fl_done ? ans : ~last_ff;

    always_comb
    begin
        ans = '{8'hFF, 1'b0, 1'b0};
        case (req_ff.fop)
            NBM_FOP_MARK: ans.data = marker(req_ff.blk, req_ff.pg);
            NBM_FOP_STATUS: ans.data = {7'h00, last_blk_ff == fail_blk};
            NBM_FOP_READ:
            begin
                ans.data = req_ff.blk[7:0];
                ans.ecc_fixed = req_ff.pg == 6'h3E;
                ans.ecc_uncor = req_ff.pg == 6'h3F;
            end
            default: ans.data = 8'h00;
        endcase
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            busy_ff <= 1'b0;
            cnt_ff <= 3'h0;
            req_ff <= '0;
            last_blk_ff <= 10'h3FF;
            last_ff <= '0;
            viol_ff <= 8'h00;
            scanned_ff <= 11'h000;
            stat_due_ff <= 1'b0;
            for (int i = 0; i < 1024; i++)
                pg_ff[i] <= 7'h00;
        end
        else if (accept)
        begin
            busy_ff <= 1'b1;
            cnt_ff <= slow ? 3'h5 : 3'h1;
            req_ff <= fl_req;
            if (is_prog || is_erase)
                last_blk_ff <= fl_req.blk;
            stat_due_ff <= is_prog || is_erase;
            if (fl_req.fop == NBM_FOP_MARK && fl_req.pg == 6'h00)
                scanned_ff <= scanned_ff + 11'h001;
            if (bad_erase || bad_order || early_write || stat_skip)
                viol_ff <= viol_ff + 8'h01;
            if (is_prog)
                pg_ff[fl_req.blk] <= {1'b1, fl_req.pg};
            if (is_erase)
                pg_ff[fl_req.blk] <= 7'h00;
        end
        else if (fl_done)
        begin
            busy_ff <= 1'b0;
            last_ff <= ans;
        end
        else if (busy_ff)
            cnt_ff <= cnt_ff - 3'h1;
    end
endmodule

/* File: sim/nbm_manager_bench.sv */
// Self-checking bench for the bad-block manager
`timescale 1ns/1ns
module nbm_manager_bench
    import nbm_pkg::*;
;
    logic mclk, nrst, cmd_valid, cmd_ready, rsp_valid, fl_valid, fl_ready, fl_done;
    logic scan_done, scan_ok, slow;
    logic [10:0] bad_count;
    logic [9:0] fail_blk;
    logic [7:0] viol;
    nbm_cmd_type cmd;
    nbm_rsp_type rsp;
    nbm_freq_type fl_req;
    nbm_frsp_type fl_rsp;
    int n_mismatch = 0;
    int compares = 0;

    nbm_manager dut_u (.mclk(mclk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp), .fl_valid(fl_valid), .fl_ready(fl_ready),
        .fl_req(fl_req), .fl_done(fl_done), .fl_rsp(fl_rsp), .scan_done(scan_done),
        .scan_ok(scan_ok), .bad_count(bad_count));
    nbm_flash_model model_u (.mclk(mclk), .nrst(nrst), .fl_valid(fl_valid),
        .fl_ready(fl_ready), .fl_req(fl_req), .fl_done(fl_done), .fl_rsp(fl_rsp),
        .fail_blk(fail_blk), .slow(slow), .viol_ff(viol));

    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // One command, held until taken, then the single response judged
    task automatic do_cmd(input nbm_uop_type u, input logic [9:0] b, input logic [5:0] p,
        input nbm_rc_type exp);
        int k;
        cmd_valid = 1'b1;
        cmd = '{u, b, p};
        k = 0;
        while (cmd_ready !== 1'b1 && k < 100)
        begin
            @(negedge mclk);
            k++;
        end
        chk(cmd_ready, 1'b1);
        @(negedge mclk);
        cmd_valid = 1'b0;
        k = 0;
        while (rsp_valid !== 1'b1 && k < 200)
        begin
            @(negedge mclk);
            k++;
        end
        chk(rsp_valid, 1'b1);
        chk(rsp.code, exp);
        chk(rsp.blk, b);
        chk(rsp.pg, p);
        @(negedge mclk);
    endtask

    task automatic t_scan();
        int k;
        chk(cmd_ready, 1'b0);
        chk(fl_valid, 1'b1);
        chk(fl_req, {NBM_FOP_MARK, 10'h001, NBM_MARK_PAGE0});
        k = 0;
        while (scan_done !== 1'b1 && k < 60000)
        begin
            @(negedge mclk);
            k++;
        end
        chk(scan_done, 1'b1);
        chk(bad_count, 11'h003);
        chk(scan_ok, 1'b1);
        do_cmd(NBM_UOP_PROG, NBM_BOOT_BLOCK, 6'h00, NBM_RC_OK);
        $display("scan test done");
    endtask

    task automatic t_refuse();
        do_cmd(NBM_UOP_ERASE, 10'h005, 6'h00, NBM_RC_BAD_BLOCK);
        do_cmd(NBM_UOP_ERASE, 10'h3FF, 6'h00, NBM_RC_BAD_BLOCK);
        do_cmd(NBM_UOP_PROG, 10'h009, 6'h04, NBM_RC_BAD_BLOCK);
        do_cmd(NBM_UOP_READ, 10'h005, 6'h01, NBM_RC_OK);
        $display("refuse test done");
    endtask

    task automatic t_order();
        do_cmd(NBM_UOP_PROG, 10'h014, 6'h0A, NBM_RC_OK);
        do_cmd(NBM_UOP_PROG, 10'h014, 6'h0A, NBM_RC_ORDER);
        do_cmd(NBM_UOP_PROG, 10'h014, 6'h03, NBM_RC_ORDER);
        do_cmd(NBM_UOP_PROG, 10'h014, 6'h0B, NBM_RC_OK);
        slow = 1'b1;
        do_cmd(NBM_UOP_ERASE, 10'h014, 6'h00, NBM_RC_OK);
        do_cmd(NBM_UOP_PROG, 10'h014, 6'h00, NBM_RC_OK);
        slow = 1'b0;
        $display("order test done");
    endtask

    task automatic t_fail();
        fail_blk = 10'h01E;
        do_cmd(NBM_UOP_PROG, 10'h01E, 6'h02, NBM_RC_FAIL);
        chk(bad_count, 11'h004);
        do_cmd(NBM_UOP_ERASE, 10'h01E, 6'h00, NBM_RC_BAD_BLOCK);
        fail_blk = 10'h021;
        do_cmd(NBM_UOP_ERASE, 10'h021, 6'h00, NBM_RC_FAIL);
        chk(bad_count, 11'h005);
        fail_blk = 10'h3FF;
        $display("fail test done");
    endtask

    task automatic t_ecc();
        do_cmd(NBM_UOP_READ, 10'h028, 6'h3F, NBM_RC_ECC_UNCOR);
        do_cmd(NBM_UOP_READ, 10'h028, 6'h3E, NBM_RC_ECC_FIXED);
        do_cmd(NBM_UOP_READ, 10'h028, 6'h00, NBM_RC_OK);
        chk(viol, 8'h00);
        $display("ecc test done");
    endtask

    // Mid-run reset: table is volatile, so the scan must run again
    task automatic t_reset();
        nrst = 1'b0;
        repeat (2) @(negedge mclk);
        chk({scan_done, scan_ok, cmd_ready, rsp_valid, fl_valid}, 5'h00);
        chk(bad_count, 11'h000);
        nrst = 1'b1;
        @(negedge mclk);
        t_scan();
        chk(viol, 8'h00);
        $display("reset test done");
    endtask

    initial
    begin
        // Two scans of about 7k cycles each; generous margin
        #(80000 * 20);
        n_mismatch++;
        summarize();
    end

    initial
    begin
        nrst = 1'b0;
        cmd_valid = 1'b0;
        cmd = '0;
        fail_blk = 10'h3FF;
        slow = 1'b0;
        repeat (7) @(negedge mclk);
        nrst = 1'b1;
        @(negedge mclk);
        t_scan();
        t_refuse();
        t_order();
        t_fail();
        t_ecc();
        t_reset();
        summarize();
    end
endmodule
